// ### rtl/event_matcher.sv
// Selects one core indication from an event code and unit qualifier
`timescale 1ns/1ns
module event_matcher #(
  parameter int unsigned COUNTER_INDEX = 0
) (
  input wire logic [7:0] code,
  input wire logic [7:0] unit_qualifier_mask,
  input wire perf_event_pkg::core_events_s events,
  output logic hit
);

  logic counter_zero;
  logic cache_hit;
  logic bus_hit;

  assign counter_zero = (COUNTER_INDEX == 0);

  assign cache_hit = events.cache_access && |(events.cache_line_state & unit_qualifier_mask[3:0]);

  assign bus_hit = events.bus_txn_self
    || (unit_qualifier_mask[perf_event_pkg::BUS_ANY_BIT] && events.bus_txn_other);

  always_comb begin
    case (code)
      perf_event_pkg::EV_FP_COMPUTE: hit = counter_zero && events.fp_compute_executed;
      perf_event_pkg::EV_DIVIDER_BUSY: hit = counter_zero && events.divider_busy;
      perf_event_pkg::EV_LOAD_BLOCKED: hit = events.load_blocked;
      perf_event_pkg::EV_STORE_DRAIN: hit = events.store_queue_drain;
      perf_event_pkg::EV_UNALIGNED_REF: hit = events.unaligned_data_ref;
      perf_event_pkg::EV_SEGMENT_LOAD: hit = events.segment_load;
      perf_event_pkg::EV_RETIRED_INSN: hit = events.instruction_retired;
      perf_event_pkg::EV_RETIRED_UOP: hit = events.microop_retired;
      perf_event_pkg::EV_DECODED_INSN: hit = events.instruction_decoded;
      perf_event_pkg::EV_IRQ_RECEIVED: hit = events.irq_received;
      perf_event_pkg::EV_IRQ_DISABLED: hit = events.irq_disabled;
      perf_event_pkg::EV_IRQ_PENDING_DISABLED: hit = events.irq_disabled && events.irq_pending;
      perf_event_pkg::EV_RETIRED_BRANCH: hit = events.branch_retired;
      perf_event_pkg::EV_RETIRED_MISPREDICT: hit = events.branch_retired && events.branch_mispredicted;
      perf_event_pkg::EV_RETIRED_TAKEN_MISPREDICT:
        hit = events.branch_retired && events.branch_mispredicted && events.branch_taken;
      perf_event_pkg::EV_RETIRED_TAKEN: hit = events.branch_retired && events.branch_taken;
      perf_event_pkg::EV_DECODED_BRANCH: hit = events.branch_decoded;
      perf_event_pkg::EV_TARGET_BUFFER_MISS: hit = events.target_buffer_miss;
      perf_event_pkg::EV_SPURIOUS_BRANCH: hit = events.spurious_branch;
      perf_event_pkg::EV_PARTIAL_ALIAS_STALL: hit = events.partial_alias_stall;
      perf_event_pkg::EV_CACHE_ACCESS: hit = cache_hit;
      perf_event_pkg::EV_BUS_TRANSACTION: hit = bus_hit;
      default: hit = 1'b0;
    endcase
  end

endmodule : event_matcher

// ### rtl/perf_event_pkg.sv
// Shared constants and carriers for the performance event select and count block
package perf_event_pkg;

  // ****************************************************************
  // Register map (byte addresses on the APB)
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_SELECTOR_ZERO = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_SELECTOR_ONE = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_ZERO = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_ONE = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;

  // ****************************************************************
  // Event selector layout
  // ****************************************************************
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned QUAL_LSB = 8;
  localparam int unsigned USER_BIT = 16;
  localparam int unsigned SUPERVISOR_BIT = 17;
  localparam int unsigned OCCURRENCE_BIT = 18;
  localparam int unsigned ENABLE_BIT = 22;
  localparam int unsigned BUS_ANY_BIT = 5;
  localparam logic [31:0] SELECTOR_WMASK = 32'h0047FFFF;
  localparam logic [31:0] SELECTOR_RESET = 32'h00000000;
  localparam logic [31:0] COUNTER_RESET = 32'h00000000;

  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic enable;
    logic [2:0] rsvd_mid;
    logic occurrence;
    logic supervisor_level_count;
    logic user_level_count;
    logic [7:0] unit_qualifier_mask;
    logic [7:0] code;
  } selector_s;

  // ****************************************************************
  // Event codes
  // ****************************************************************
  localparam logic [7:0] EV_LOAD_BLOCKED = 8'h03;
  localparam logic [7:0] EV_STORE_DRAIN = 8'h04;
  localparam logic [7:0] EV_UNALIGNED_REF = 8'h05;
  localparam logic [7:0] EV_SEGMENT_LOAD = 8'h06;
  localparam logic [7:0] EV_FP_COMPUTE = 8'h10;
  localparam logic [7:0] EV_DIVIDER_BUSY = 8'h14;
  localparam logic [7:0] EV_RETIRED_INSN = 8'hC0;
  localparam logic [7:0] EV_RETIRED_UOP = 8'hC2;
  localparam logic [7:0] EV_RETIRED_BRANCH = 8'hC4;
  localparam logic [7:0] EV_RETIRED_MISPREDICT = 8'hC5;
  localparam logic [7:0] EV_IRQ_DISABLED = 8'hC6;
  localparam logic [7:0] EV_IRQ_PENDING_DISABLED = 8'hC7;
  localparam logic [7:0] EV_IRQ_RECEIVED = 8'hC8;
  localparam logic [7:0] EV_RETIRED_TAKEN = 8'hC9;
  localparam logic [7:0] EV_RETIRED_TAKEN_MISPREDICT = 8'hCA;
  localparam logic [7:0] EV_DECODED_INSN = 8'hD0;
  localparam logic [7:0] EV_PARTIAL_ALIAS_STALL = 8'hD2;
  localparam logic [7:0] EV_DECODED_BRANCH = 8'hE0;
  localparam logic [7:0] EV_TARGET_BUFFER_MISS = 8'hE2;
  localparam logic [7:0] EV_SPURIOUS_BRANCH = 8'hE4;
  localparam logic [7:0] EV_CACHE_ACCESS = 8'h2E;
  localparam logic [7:0] EV_BUS_TRANSACTION = 8'h70;

  // ****************************************************************
  // Indications from the core units, all on pclk
  // ****************************************************************
  typedef struct packed {
    logic fp_compute_executed;
    logic divider_busy;
    logic load_blocked;
    logic store_queue_drain;
    logic unaligned_data_ref;
    logic segment_load;
    logic instruction_retired;
    logic microop_retired;
    logic instruction_decoded;
    logic irq_received;
    logic irq_disabled;
    logic irq_pending;
    logic branch_retired;
    logic branch_mispredicted;
    logic branch_taken;
    logic branch_decoded;
    logic target_buffer_miss;
    logic spurious_branch;
    logic partial_alias_stall;
    logic cache_access;
    logic [3:0] cache_line_state;
    logic bus_txn_self;
    logic bus_txn_other;
  } core_events_s;

endpackage : perf_event_pkg

// ### rtl/perf_event_select_decode.sv
// Two performance counters with event selectors behind an APB slave
//
// Notes on behaviour
// - Code 10H counts floating point, counter zero.
// - Code 14H counts divider busy, counter zero.
// - Code 03H counts loads blocked by stores.
// - Code 04H counts store buffer drain cycles.
// - Code 05H counts misaligned data references.
// - Code C0H counts retired instructions.
// - Code C2H counts retired micro-operations.
// - Code D0H counts decoded instructions.
// - Code C8H counts hardware interrupts received.
// - Code C6H counts interrupts-disabled cycles.
// - Code C7H counts disabled-and-pending cycles.
// - Code C4H counts retired branches.
// - C5H mispredicted retired; CAH taken mispredicted.
// - Code C9H counts retired taken branches.
// - Code E0H counts decoded branches.
// - Code E2H counts target buffer misses.
// - Code E4H counts spurious branches.
// - Code D2H counts partial alias stalls.
// - Code 06H counts segment register loads.
// - Qualifier bits 3..0 select line states.
// - State mask FH counts all, zero none.
// - Qualifier bit 5 picks self or any.
// - Code bits 7:0, qualifier bits 15:8.
// - Bit 18 occurrence, else duration cycles.
// - Bit 17 level zero, bit 16 others.
// - Bit 22 of selector zero enables both counters together.
`timescale 1ns/1ns
module perf_event_select_decode #(
  parameter int unsigned COUNTER_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [perf_event_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire perf_event_pkg::core_events_s events,
  input wire logic [1:0] privilege_level,
  output logic [1:0] counting
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  localparam int unsigned NUM_COUNTERS = 2;

  logic setup_phase;
  logic write_access;
  logic hit_sel0;
  logic hit_sel1;
  logic hit_ctr0;
  logic hit_ctr1;
  logic hit_status;
  logic mapped;
  logic [31:0] strobe_mask;
  logic [31:0] next_rdata;

  assign setup_phase = psel && !penable;
  // Writes land at the completing edge of the access phase only
  assign write_access = psel && penable && pwrite;

  assign hit_sel0 = (paddr == perf_event_pkg::OFS_SELECTOR_ZERO);
  assign hit_sel1 = (paddr == perf_event_pkg::OFS_SELECTOR_ONE);
  assign hit_ctr0 = (paddr == perf_event_pkg::OFS_COUNTER_ZERO);
  assign hit_ctr1 = (paddr == perf_event_pkg::OFS_COUNTER_ONE);
  assign hit_status = (paddr == perf_event_pkg::OFS_STATUS);
  assign mapped = hit_sel0 || hit_sel1 || hit_ctr0 || hit_ctr1 || hit_status;

  // Byte lanes expanded to a bit mask
  assign strobe_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // ****************************************************************
  // Event selectors
  // ****************************************************************
  logic [31:0] selector_raw [NUM_COUNTERS];
  perf_event_pkg::selector_s selector [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] selector_write;

  assign selector_write[0] = write_access && hit_sel0;
  assign selector_write[1] = write_access && hit_sel1;

  // ****************************************************************
  // Counters and their qualification
  // ****************************************************************
  logic [COUNTER_W-1:0] count [NUM_COUNTERS];
  logic [NUM_COUNTERS-1:0] counter_write;
  logic [NUM_COUNTERS-1:0] hit;
  logic [NUM_COUNTERS-1:0] hit_prev;
  logic [NUM_COUNTERS-1:0] level_ok;
  logic [NUM_COUNTERS-1:0] bump;
  logic common_enable;
  logic supervisor;

  assign counter_write[0] = write_access && hit_ctr0;
  assign counter_write[1] = write_access && hit_ctr1;

  assign common_enable = selector[0].enable;
  assign supervisor = (privilege_level == 2'h0);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_counter
      logic [31:0] next_selector;

      assign selector[gi] = perf_event_pkg::selector_s'(selector_raw[gi]);

      // Reserved bits never store, so they read back as zero
      assign next_selector = ((selector_raw[gi] & ~strobe_mask) | (pwdata & strobe_mask))
        & perf_event_pkg::SELECTOR_WMASK;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          selector_raw[gi] <= perf_event_pkg::SELECTOR_RESET;
        end else if (selector_write[gi]) begin
          selector_raw[gi] <= next_selector;
        end
      end

      event_matcher #(
        .COUNTER_INDEX(gi)
      ) u_matcher (
        .code(selector[gi].code),
        .unit_qualifier_mask(selector[gi].unit_qualifier_mask),
        .events(events),
        .hit(hit[gi])
      );

      assign level_ok[gi] = (supervisor && selector[gi].supervisor_level_count)
        || (!supervisor && selector[gi].user_level_count);

      // occurrence counts rising edges, duration counts cycles
      assign bump[gi] = common_enable && level_ok[gi]
        && (selector[gi].occurrence ? (hit[gi] && !hit_prev[gi]) : hit[gi]);

      // The edge history keeps running while disabled so enabling mid-event does not count it
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hit_prev[gi] <= 1'b0;
        end else begin
          hit_prev[gi] <= hit[gi];
        end
      end

      // A software write wins over an increment in the same cycle
      // increment by exactly one
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          count[gi] <= COUNTER_W'(perf_event_pkg::COUNTER_RESET);
        end else if (counter_write[gi]) begin
          count[gi] <= COUNTER_W'((32'(count[gi]) & ~strobe_mask) | (pwdata & strobe_mask));
        end else if (bump[gi]) begin
          count[gi] <= count[gi] + COUNTER_W'(1);
        end
      end

      assign counting[gi] = bump[gi];
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Read data is captured in the setup cycle, so a read shows the
  // counter as it stood one cycle before the completing edge.
  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_sel0) begin
      next_rdata = selector_raw[0];
    end else if (hit_sel1) begin
      next_rdata = selector_raw[1];
    end else if (hit_ctr0) begin
      next_rdata = 32'(count[0]);
    end else if (hit_ctr1) begin
      next_rdata = 32'(count[1]);
    end else if (hit_status) begin
      next_rdata = {26'h0000000, supervisor, common_enable, level_ok, hit};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= !mapped;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready = psel && penable;

endmodule : perf_event_select_decode

// ### verif/core_unit_model.sv
// Behavioural core units raising the indications behind one event code
`timescale 1ns/1ns
module core_unit_model (
  input wire logic [7:0] code,
  input wire logic active,
  input wire logic partial,
  input wire logic [3:0] state,
  output perf_event_pkg::core_events_s events
);
  // Idle units drive no indication; partial drops the last qualifier
  always_comb begin
    events = '0;
    if (active) begin
      case (code)
        8'h10: events.fp_compute_executed = 1'h1;
        8'h14: events.divider_busy = 1'h1;
        8'h03: events.load_blocked = 1'h1;
        8'h04: events.store_queue_drain = 1'h1;
        8'h05: events.unaligned_data_ref = 1'h1;
        8'h06: events.segment_load = 1'h1;
        8'hC0: events.instruction_retired = 1'h1;
        8'hC2: events.microop_retired = 1'h1;
        8'hD0: events.instruction_decoded = 1'h1;
        8'hC8: events.irq_received = 1'h1;
        8'hC6: events.irq_disabled = 1'h1;
        8'hC7: begin
          events.irq_disabled = 1'h1;
          events.irq_pending = !partial;
        end
        8'hC4: events.branch_retired = 1'h1;
        8'hC5: events = {12'h000, 3'h6, 11'h000};
        8'hC9: events = {12'h000, 3'h5, 11'h000};
        8'hCA: events = {12'h000, 3'h7, 11'h000} & ~{14'h0000, partial, 11'h000};
        8'hE0: events.branch_decoded = 1'h1;
        8'hE2: events.target_buffer_miss = 1'h1;
        8'hE4: events.spurious_branch = 1'h1;
        8'hD2: events.partial_alias_stall = 1'h1;
        8'h2E: events = {19'h00000, 1'h1, state, 2'h0};
        8'h70: events = {24'h000000, !partial, 1'h1};
        default: events = '0;
      endcase
    end
  end
endmodule : core_unit_model

// ### verif/perf_event_select_decode_sva.sv
// Port-level assertions for the event decode and counters
`timescale 1ns/1ns
module perf_event_select_decode_sva #(
  parameter int unsigned COUNTER_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [perf_event_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire perf_event_pkg::core_events_s events,
  input wire logic [1:0] privilege_level,
  input wire logic [1:0] counting
);
  logic [31:0] sh0;
  logic [31:0] sh1;
  wire wr = psel && penable && pwrite;
  wire ok0 = (privilege_level == 2'h0) ? sh0[17] : sh0[16];
  // Selector copies follow each write lane by lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh0 <= '0;
      sh1 <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr && pstrb[i] && paddr == perf_event_pkg::OFS_SELECTOR_ZERO) sh0[8*i +: 8] <= pwdata[8*i +: 8];
        if (wr && pstrb[i] && paddr == perf_event_pkg::OFS_SELECTOR_ONE) sh1[8*i +: 8] <= pwdata[8*i +: 8];
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_enable_gates_both: assert property (!sh0[22] |-> counting == 2'h0)
    else $error("counting while disabled");
  a_zero_only_codes: assert property (sh1[7:0] inside {8'h10, 8'h14} |-> !counting[1])
    else $error("counter one took a counter zero event");
  a_level_zero_gate: assert property (privilege_level == 2'h0 && !sh0[17] |-> !counting[0])
    else $error("counted at level zero");
  a_user_level_gate: assert property (privilege_level != 2'h0 && !sh0[16] |-> !counting[0])
    else $error("counted at user level");
  a_occurrence_once: assert property (sh0[18] && counting[0] && !wr |=> !counting[0])
    else $error("occurrence counted twice");
  a_retired_counts: assert property (sh0[7:0] == 8'hC0 && !sh0[18] && sh0[22] && ok0 && !wr
    && events.instruction_retired |-> counting[0]) else $error("retired instruction missed");
  a_pending_needed: assert property (counting[1] && sh1[7:0] == 8'hC7 && !sh1[18]
    |-> events.irq_disabled && events.irq_pending) else $error("counted without pending");
  a_state_mask_none: assert property (sh0[7:0] == 8'h2E && sh0[11:8] == 4'h0 |-> !counting[0])
    else $error("empty state mask counted");
  a_self_only_bus: assert property (counting[1] && sh1[7:0] == 8'h70 && !sh1[13] && !sh1[18]
    |-> events.bus_txn_self) else $error("foreign bus cycle counted");
  a_taken_mispredict: assert property (counting[0] && sh0[7:0] == 8'hCA && !sh0[18]
    |-> events.branch_mispredicted && events.branch_taken) else $error("untaken mispredict counted");
endmodule : perf_event_select_decode_sva
bind perf_event_select_decode perf_event_select_decode_sva #(.COUNTER_W(COUNTER_W)) sva (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .events, .privilege_level,
  .counting);

// ### verif/tb_top.sv
// Self-checking bench: selectors and counters over APB, events from the core model
`timescale 1ns/1ns
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, active, partial, slv;
  logic [perf_event_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, state;
  logic [1:0] privilege_level, counting;
  logic [7:0] code;
  perf_event_pkg::core_events_s events;
  int err_count, total_checks;
  logic [7:0] codes [20] = '{8'h10, 8'h14, 8'h03, 8'h04, 8'h05, 8'h06, 8'hC0, 8'hC2, 8'hD0, 8'hC8,
    8'hC6, 8'hC7, 8'hC4, 8'hC5, 8'hC9, 8'hCA, 8'hE0, 8'hE2, 8'hE4, 8'hD2};
  localparam logic [31:0] DUR = 32'h00430000;
  perf_event_select_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .events(events), .privilege_level(privilege_level), .counting(counting));
  core_unit_model core (.code(code), .active(active), .partial(partial), .state(state), .events(events));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Ends one idle cycle after release so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [perf_event_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  // Events stand three cycles, then the counter is read back
  task automatic run(input logic c, input logic [31:0] base, input logic [7:0] cd, input logic [7:0] q,
      input logic part, input logic [3:0] st, input logic [1:0] lvl, input logic [31:0] exp);
    logic [perf_event_pkg::ADDR_W-1:0] sa;
    logic [perf_event_pkg::ADDR_W-1:0] ca;
    sa = c ? perf_event_pkg::OFS_SELECTOR_ONE : perf_event_pkg::OFS_SELECTOR_ZERO;
    ca = c ? perf_event_pkg::OFS_COUNTER_ONE : perf_event_pkg::OFS_COUNTER_ZERO;
    if (c) apb(1'h1, perf_event_pkg::OFS_SELECTOR_ZERO, 32'h00400000);
    apb(1'h1, sa, base | {16'h0000, q, cd});
    apb(1'h1, ca, 32'h00000000);
    code <= cd;
    partial <= part;
    state <= st;
    privilege_level <= lvl;
    active <= 1'h1;
    repeat (3) @(posedge pclk);
    active <= 1'h0;
    @(posedge pclk);
    apb(1'h0, ca, 32'h00000000);
    check(rd, exp);
  endtask : run
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, active, partial} = 6'h00;
    {paddr, pwdata, code, state, privilege_level} = '0;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, perf_event_pkg::OFS_SELECTOR_ZERO, 32'h00000000);
    check(rd, perf_event_pkg::SELECTOR_RESET);
    // Level zero, nothing enabled and no selected event after reset
    apb(1'h0, perf_event_pkg::OFS_STATUS, 32'h00000000);
    check(rd, 32'h00000020);
    apb(1'h1, perf_event_pkg::OFS_SELECTOR_ONE, 32'hFFFFFFFF);
    apb(1'h0, perf_event_pkg::OFS_SELECTOR_ONE, 32'h00000000);
    check(rd, perf_event_pkg::SELECTOR_WMASK);
    apb(1'h0, 12'h020, 32'h00000000);
    check({rd[30:0], slv}, 32'h00000001);
    for (int i = 0; i < 20; i++) run(1'h0, DUR, codes[i], 8'h00, 1'h0, 4'h0, 2'h0, 32'h3);
    run(1'h1, DUR, 8'h10, 8'h00, 1'h0, 4'h0, 2'h0, 32'h0);
    run(1'h1, DUR, 8'h14, 8'h00, 1'h0, 4'h0, 2'h0, 32'h0);
    run(1'h0, DUR, 8'hC7, 8'h00, 1'h1, 4'h0, 2'h0, 32'h0);
    run(1'h1, DUR, 8'hC7, 8'h00, 1'h0, 4'h0, 2'h0, 32'h3);
    run(1'h0, DUR, 8'hCA, 8'h00, 1'h1, 4'h0, 2'h0, 32'h0);
    run(1'h0, 32'h00470000, 8'hC0, 8'h00, 1'h0, 4'h0, 2'h0, 32'h1);
    run(1'h0, 32'h00410000, 8'hC0, 8'h00, 1'h0, 4'h0, 2'h0, 32'h0);
    run(1'h0, 32'h00410000, 8'hC0, 8'h00, 1'h0, 4'h0, 2'h2, 32'h3);
    run(1'h0, 32'h00420000, 8'hC0, 8'h00, 1'h0, 4'h0, 2'h3, 32'h0);
    run(1'h0, 32'h00420000, 8'hC0, 8'h00, 1'h0, 4'h0, 2'h0, 32'h3);
    run(1'h0, 32'h00030000, 8'hC0, 8'h00, 1'h0, 4'h0, 2'h0, 32'h0);
    for (int j = 0; j < 4; j++) begin
      run(1'h0, DUR, 8'h2E, 8'h01 << j, 1'h0, 4'h1 << j, 2'h0, 32'h3);
      run(1'h0, DUR, 8'h2E, 8'h01 << j, 1'h0, 4'h1 << ((j + 1) % 4), 2'h0, 32'h0);
    end
    run(1'h0, DUR, 8'h2E, 8'h0F, 1'h0, 4'h8, 2'h0, 32'h3);
    run(1'h0, DUR, 8'h2E, 8'h00, 1'h0, 4'hF, 2'h0, 32'h0);
    run(1'h1, DUR, 8'h70, 8'h00, 1'h1, 4'h0, 2'h0, 32'h0);
    run(1'h1, DUR, 8'h70, 8'h20, 1'h1, 4'h0, 2'h0, 32'h3);
    run(1'h1, DUR, 8'h70, 8'h00, 1'h0, 4'h0, 2'h0, 32'h3);
    give_verdict();
  end
  // Whole sequence needs about 620 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
endmodule : tb_top
